/* File: telemetry_log_read_handler.sv */
// telemetry_log_read_handler.sv - drive-side server of the telemetry log and
// the block-interrupt multi-sector read
// assumes: command, data and media ports come from logic on mclk
//
// Overview of operation
// - A log page is 16KiB; a count of 32 sectors reads one page.
// - The page number field of the address selects the starting page.
// - A count of 192 returns all six pages in one transfer.
// - Page 0 is a header; pages 1 to 5 carry statistics.
// - Header bytes 0 to 7 hold the reversed LOGGER signature.
// - Header qwords from byte 8 give revisions 2, 1 and 0.
// - Header gives page count, 96KiB log size and 16KiB page size.
// - Header qword at byte 56 reports 24 heads; rest is reserved.
// - Stat pages start with page number, copy number, then fields.
// - Each field is a qword: status in byte 7, data below.
// - Status bit 7 flags support; bits 4 to 0 are reserved.
// - Status bit 6 stays 0 until the field has settled.
// - Status bit 5 marks a field that restarts on a whole pull.
// - A partial read never clears the limited fields.
// - Limited fields clear only after one command moved all 96KiB.
// - Opcode 47h; log address in 7:0, page in 15:8 and 39:32.
// - The DMA log read returns what the non-DMA log read returns.
// - Opcode C4h reads count sectors, 00h meaning 256, from the address.
// - Each sector is fetched from media before it is delivered.
// - Sector data leaves in 16-bit words.
// - One interrupt per configured block, not per sector.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
`include "tlrh_cfg.svh"
module telemetry_log_read_handler #(
    parameter int          CNT_W        = 32,
    parameter logic [7:0]  LOG_ADDR     = 8'hC0,
    parameter logic [31:0] VALID_CYCLES = 32'h017D_7840
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        cmdValid,
    input  wire logic [7:0]  cmdOpcode,
    input  wire logic [15:0] cmdCount,
    input  wire logic [47:0] cmdLba,
    output logic             cmdDone,
    output logic             cmdError,
    output logic             busy,
    output logic [15:0]      dataWord,
    output logic             dataValid,
    input  wire logic        dataReady,
    output logic             mediaReq,
    output logic [47:0]      mediaLba,
    input  wire logic        mediaValid,
    input  wire logic [15:0] mediaWord,
    output logic             blockIrq,
    input  wire logic [4:0]  statEvent,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdData
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        tlrh_pkg::tlrh_state_t st;
        logic [15:0]           wordCnt;
        logic [15:0]           wordTotal;
        logic [2:0]            startPage;
        logic                  whole;
        logic [8:0]            secLeft;
        logic [7:0]            blkCnt;
        logic [47:0]           lba;
        logic [8:0]            bufIdx;
        logic [15:0]           dataWord;
        logic                  dataValid;
        logic                  mediaReq;
        logic                  blockIrq;
        logic                  cmdDone;
        logic                  cmdError;
        logic                  busy;
        logic [7:0]            multSize;
        logic [31:0]           regRdData;
        logic [31:0]           upTime;
        logic                  fieldValid;
        logic [15:0]           pullCount;
        logic [4:0][CNT_W-1:0] lifeCnt;
        logic [4:0][CNT_W-1:0] limCnt;
    } tlrh_regs_t;

    tlrh_regs_t  s;
    tlrh_regs_t  next_s;
    logic [15:0] sectorBuf [256];
    logic [15:0] reqPage;
    logic [15:0] reqEnd;
    logic        logOk;
    logic        logWhole;
    logic        logFin;

    tlrh_field_if #(.CNT_W(CNT_W)) fld ();

    tlrh_field_gen #(.CNT_W(CNT_W)) u_field_gen (
        .fld (fld)
    );

    generate
        if (VALID_CYCLES == 32'h0000_0000) begin : g_bad_valid
            $error("VALID_CYCLES must be nonzero");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------------
    // both log opcodes share one path, so their content cannot diverge
    function automatic logic isLogOp(input logic [7:0] op);
        isLogOp = (op == `TLRH_OP_LOG_DMA) || (op == `TLRH_OP_LOG_PIO);
    endfunction

    assign reqPage  = {cmdLba[39:32], cmdLba[15:8]};
    assign reqEnd   = reqPage + {5'h00, cmdCount[15:5]};
    // feature field is never looked at
    assign logOk    = (cmdLba[7:0] == LOG_ADDR) && (cmdCount != 16'h0000)
                      && (cmdCount[4:0] == 5'h00) && (reqPage < `TLRH_PAGES)
                      && (reqEnd <= `TLRH_PAGES);
    assign logWhole = (reqPage == 16'h0000) && (cmdCount == `TLRH_WHOLE_COUNT);

    assign fld.page       = s.startPage + s.wordCnt[15:13];
    assign fld.qwIdx      = s.wordCnt[12:2];
    assign fld.fieldValid = s.fieldValid;
    assign fld.lifeCnt    = s.lifeCnt;
    assign fld.limCnt     = s.limCnt;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_s = s;
        logFin = 1'b0;
        next_s.cmdDone   = 1'b0;
        next_s.cmdError  = 1'b0;
        next_s.blockIrq  = 1'b0;
        next_s.mediaReq  = 1'b0;
        next_s.regRdData = 32'h0000_0000;

        // settle timer since reset
        if (s.upTime != VALID_CYCLES) begin
            next_s.upTime = s.upTime + 32'h0000_0001;
        end else begin
            next_s.fieldValid = 1'b1;
        end

        for (int i = 0; i < 5; i++) begin
            if (statEvent[i]) begin
                next_s.lifeCnt[i] = s.lifeCnt[i] + CNT_W'(1);
                next_s.limCnt[i]  = s.limCnt[i] + CNT_W'(1);
            end
        end

        if (regWr && regAddr == `TLRH_REG_MULT) begin
            next_s.multSize = regWrData[7:0];
        end
        if (regRd) begin
            if (regAddr == `TLRH_REG_MULT) begin
                next_s.regRdData = {24'h00_0000, s.multSize};
            end else if (regAddr == `TLRH_REG_STATUS) begin
                next_s.regRdData = {s.pullCount, 14'h0000, s.fieldValid, s.busy};
            end else begin
                next_s.regRdData = 32'h0000_0000;
            end
        end

        case (s.st)
            tlrh_pkg::ST_IDLE: begin
                if (cmdValid) begin
                    if (isLogOp(cmdOpcode) && logOk) begin
                        next_s.st        = tlrh_pkg::ST_LOG;
                        next_s.startPage = reqPage[2:0];
                        next_s.wordTotal = {cmdCount[7:0], 8'h00};
                        next_s.wordCnt   = 16'h0000;
                        next_s.whole     = logWhole;
                    end else if (cmdOpcode == `TLRH_OP_RD_MULT
                                 && s.multSize != 8'h00) begin
                        next_s.st      = tlrh_pkg::ST_FETCH;
                        next_s.secLeft = (cmdCount[7:0] == 8'h00) ? `TLRH_SECT_WORDS
                                         : {1'b0, cmdCount[7:0]};
                        next_s.lba      = cmdLba;
                        next_s.blkCnt   = 8'h00;
                        next_s.bufIdx   = 9'h000;
                        next_s.mediaReq = 1'b1;
                    end else begin
                        // bad log request, unknown opcode, or no block size set
                        next_s.cmdError = 1'b1;
                    end
                end
            end
            tlrh_pkg::ST_LOG: begin
                if (!s.dataValid || dataReady) begin
                    if (s.wordCnt != s.wordTotal) begin
                        // qword lane 0 first keeps the low byte leading
                        next_s.dataWord  = fld.qword[{s.wordCnt[1:0], 4'h0} +: 16];
                        next_s.dataValid = 1'b1;
                        next_s.wordCnt   = s.wordCnt + 16'h0001;
                    end else begin
                        logFin           = 1'b1;
                        next_s.dataValid = 1'b0;
                        next_s.st        = tlrh_pkg::ST_IDLE;
                        next_s.cmdDone   = 1'b1;
                        if (s.whole) begin
                            next_s.pullCount = s.pullCount + 16'h0001;
                            // an event in the clearing cycle still counts
                            for (int i = 0; i < 5; i++) begin
                                next_s.limCnt[i] = CNT_W'(statEvent[i]);
                            end
                        end
                    end
                end
            end
            tlrh_pkg::ST_FETCH: begin
                if (mediaValid) begin
                    next_s.bufIdx = s.bufIdx + 9'h001;
                    if (s.bufIdx == `TLRH_LAST_WORD) begin
                        next_s.st     = tlrh_pkg::ST_SEND;
                        next_s.bufIdx = 9'h000;
                    end
                end
            end
            tlrh_pkg::ST_SEND: begin
                if (!s.dataValid || dataReady) begin
                    if (s.bufIdx != `TLRH_SECT_WORDS) begin
                        next_s.dataWord  = sectorBuf[s.bufIdx[7:0]];
                        next_s.dataValid = 1'b1;
                        next_s.bufIdx    = s.bufIdx + 9'h001;
                    end else begin
                        next_s.dataValid = 1'b0;
                        next_s.secLeft   = s.secLeft - 9'h001;
                        next_s.lba       = s.lba + 48'h0000_0000_0001;
                        next_s.blkCnt    = s.blkCnt + 8'h01;
                        // >= tolerates a block size lowered mid-command
                        if (s.blkCnt + 8'h01 >= s.multSize || s.secLeft == 9'h001) begin
                            next_s.blockIrq = 1'b1;
                            next_s.blkCnt   = 8'h00;
                        end
                        if (s.secLeft == 9'h001) begin
                            next_s.st      = tlrh_pkg::ST_IDLE;
                            next_s.cmdDone = 1'b1;
                        end else begin
                            next_s.st       = tlrh_pkg::ST_FETCH;
                            next_s.bufIdx   = 9'h000;
                            next_s.mediaReq = 1'b1;
                        end
                    end
                end
            end
            default: next_s.st = tlrh_pkg::ST_IDLE;
        endcase

        next_s.busy = (next_s.st != tlrh_pkg::ST_IDLE);
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            s          <= '0;
            s.multSize <= `TLRH_MULT_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // sector store: a whole sector lands before any word of it leaves
    always_ff @(posedge mclk) begin
        if (ce && s.st == tlrh_pkg::ST_FETCH && mediaValid) begin
            sectorBuf[s.bufIdx[7:0]] <= mediaWord;
        end
    end

    assign cmdDone   = s.cmdDone;
    assign cmdError  = s.cmdError;
    assign busy      = s.busy;
    assign dataWord  = s.dataWord;
    assign dataValid = s.dataValid;
    assign mediaReq  = s.mediaReq;
    assign mediaLba  = s.lba;
    assign blockIrq  = s.blockIrq;
    assign regRdData = s.regRdData;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    property p_log_length;
        @(posedge mclk) disable iff (reset)
        ce && s.st == tlrh_pkg::ST_IDLE && cmdValid && isLogOp(cmdOpcode) && logOk
        |=> s.st == tlrh_pkg::ST_LOG && s.wordTotal == {$past(cmdCount[7:0]), 8'h00}
            && s.startPage == $past(reqPage[2:0]);
    endproperty
    a_log_length: assert property (p_log_length)
        else $error("log transfer length or start page wrong");

    property p_signature;
        @(posedge mclk) disable iff (reset)
        s.st == tlrh_pkg::ST_LOG && fld.page == 3'h0 && fld.qwIdx == 11'h000
        |-> fld.qword == `TLRH_SIGNATURE;
    endproperty
    a_signature: assert property (p_signature)
        else $error("header signature wrong");

    property p_revision;
        @(posedge mclk) disable iff (reset)
        s.st == tlrh_pkg::ST_LOG && fld.page == 3'h0 && fld.qwIdx == 11'h001
        |-> fld.qword == `TLRH_REV_MAJOR;
    endproperty
    a_revision: assert property (p_revision)
        else $error("major revision wrong");

    property p_heads;
        @(posedge mclk) disable iff (reset)
        s.st == tlrh_pkg::ST_LOG && fld.page == 3'h0 && fld.qwIdx == 11'h007
        |-> fld.qword == `TLRH_MAX_HEADS;
    endproperty
    a_heads: assert property (p_heads)
        else $error("head count wrong");

    property p_status_byte;
        @(posedge mclk) disable iff (reset)
        fld.page != 3'h0 && fld.page < 3'h6 && (fld.qwIdx == 11'h002 || fld.qwIdx == 11'h003)
        |-> fld.qword[63] && fld.qword[60:56] == 5'h00
            && fld.qword[62] == (fld.qwIdx == 11'h002 || s.fieldValid);
    endproperty
    a_status_byte: assert property (p_status_byte)
        else $error("field status byte wrong");

    property p_partial_keeps;
        @(posedge mclk) disable iff (reset)
        ce && logFin && !s.whole && statEvent == 5'h00 |=> s.limCnt == $past(s.limCnt);
    endproperty
    a_partial_keeps: assert property (p_partial_keeps)
        else $error("partial pull disturbed limited counters");

    property p_whole_clears;
        @(posedge mclk) disable iff (reset)
        ce && logFin && s.whole && statEvent == 5'h00 |=> s.limCnt == '0 && s.cmdDone;
    endproperty
    a_whole_clears: assert property (p_whole_clears)
        else $error("whole pull did not clear limited counters");

    property p_count_zero;
        @(posedge mclk) disable iff (reset)
        ce && s.st == tlrh_pkg::ST_IDLE && cmdValid && cmdOpcode == `TLRH_OP_RD_MULT
        && cmdCount[7:0] == 8'h00 && s.multSize != 8'h00
        |=> s.secLeft == 9'h100 && s.mediaReq;
    endproperty
    a_count_zero: assert property (p_count_zero)
        else $error("count 00h not read as 256 sectors");

    property p_fetch_first;
        @(posedge mclk) disable iff (reset)
        s.st == tlrh_pkg::ST_FETCH |-> !s.dataValid;
    endproperty
    a_fetch_first: assert property (p_fetch_first)
        else $error("data offered while sector still being fetched");

    property p_irq_at_block;
        @(posedge mclk) disable iff (reset)
        s.blockIrq && $past(ce) |-> $past(s.st) == tlrh_pkg::ST_SEND
            && s.blkCnt == 8'h00 && !s.dataValid;
    endproperty
    a_irq_at_block: assert property (p_irq_at_block)
        else $error("block interrupt outside a block end");

endmodule

/* File: tlrh_cfg.svh */
// tlrh_cfg.svh - offsets, field positions, reset values and fixed log contents
// assumes: included by bare name from the telemetry log handler files
`ifndef TLRH_CFG_SVH
`define TLRH_CFG_SVH

// ----------------------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------------------
`define TLRH_OP_LOG_DMA   8'h47
`define TLRH_OP_LOG_PIO   8'h2F
`define TLRH_OP_RD_MULT   8'hC4

// ----------------------------------------------------------------------------
// log geometry
// ----------------------------------------------------------------------------
`define TLRH_PAGES        16'h0006
`define TLRH_WHOLE_COUNT  16'h00C0
`define TLRH_SECT_WORDS   9'h100
`define TLRH_LAST_WORD    9'h0FF

// ----------------------------------------------------------------------------
// header page contents
// ----------------------------------------------------------------------------
`define TLRH_SIGNATURE    64'h0000_4C4F_4747_4552
`define TLRH_REV_MAJOR    64'h0000_0000_0000_0002
`define TLRH_REV_MINOR    64'h0000_0000_0000_0001
`define TLRH_REV_SUB      64'h0000_0000_0000_0000
`define TLRH_NUM_PAGES    64'h0000_0000_0000_0006
`define TLRH_LOG_BYTES    64'h0000_0000_0001_8000
`define TLRH_PAGE_BYTES   64'h0000_0000_0000_4000
`define TLRH_MAX_HEADS    64'h0000_0000_0000_0018
`define TLRH_COPY_NUM     64'h0000_0000_0000_0000

// ----------------------------------------------------------------------------
// status byte bit positions
// ----------------------------------------------------------------------------
`define TLRH_ST_SUPPORTED 7
`define TLRH_ST_VALID     6
`define TLRH_ST_LIMITED   5

// ----------------------------------------------------------------------------
// register map and reset values
// ----------------------------------------------------------------------------
`define TLRH_REG_MULT     4'h0
`define TLRH_REG_STATUS   4'h4
`define TLRH_MULT_RST     8'h01

`endif

/* File: tlrh_pkg.sv */
// tlrh_pkg.sv - types shared by the telemetry log handler
// assumes: nothing beyond a SystemVerilog compiler
package tlrh_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOG,
        ST_FETCH,
        ST_SEND
    } tlrh_state_t;

endpackage

/* File: tlrh_field_if.sv */
// tlrh_field_if.sv - carries page/qword selection and counter values to the
// field generator and the selected qword back
// assumes: both ends sit on the same clock
`timescale 1ns/10ps
interface tlrh_field_if #(
    parameter int CNT_W = 32
) ();
    logic [2:0]            page;
    logic [10:0]           qwIdx;
    logic                  fieldValid;
    logic [4:0][CNT_W-1:0] lifeCnt;
    logic [4:0][CNT_W-1:0] limCnt;
    logic [63:0]           qword;

    modport ctl (output page, qwIdx, fieldValid, lifeCnt, limCnt, input qword);
    modport gen (input page, qwIdx, fieldValid, lifeCnt, limCnt, output qword);
endinterface

/* File: tlrh_field_gen.sv */
// tlrh_field_gen.sv - combinational builder of one telemetry log qword
// assumes: page and qword index stay stable while the qword is sampled
`timescale 1ns/10ps
`include "tlrh_cfg.svh"
module tlrh_field_gen #(
    parameter int CNT_W = 32
) (
    tlrh_field_if.gen fld
);

    logic [2:0] statIdx;

    // ------------------------------------------------------------------------
    // status byte
    // ------------------------------------------------------------------------
    function automatic logic [7:0] statusOf(input logic valid, input logic limited);
        logic [7:0] b;
        b = 8'h00;
        b[`TLRH_ST_SUPPORTED] = 1'b1;
        b[`TLRH_ST_VALID] = valid;
        b[`TLRH_ST_LIMITED] = limited;
        statusOf = b;
    endfunction

    generate
        if (CNT_W < 1 || CNT_W > 56) begin : g_bad_width
            $error("counter width must be 1..56");
        end
    endgenerate

    assign statIdx = fld.page - 3'h1;

    // ------------------------------------------------------------------------
    // qword select
    // ------------------------------------------------------------------------
    always_comb begin
        fld.qword = 64'h0000_0000_0000_0000;
        if (fld.page == 3'h0) begin
            case (fld.qwIdx)
                11'h000: fld.qword = `TLRH_SIGNATURE;
                11'h001: fld.qword = `TLRH_REV_MAJOR;
                11'h002: fld.qword = `TLRH_REV_MINOR;
                11'h003: fld.qword = `TLRH_REV_SUB;
                11'h004: fld.qword = `TLRH_NUM_PAGES;
                11'h005: fld.qword = `TLRH_LOG_BYTES;
                11'h006: fld.qword = `TLRH_PAGE_BYTES;
                11'h007: fld.qword = `TLRH_MAX_HEADS;
                default: fld.qword = 64'h0000_0000_0000_0000;
            endcase
        end else if (fld.page < 3'h6) begin
            case (fld.qwIdx)
                11'h000: fld.qword = {61'h0, fld.page};
                11'h001: fld.qword = `TLRH_COPY_NUM;
                // lifetime count: always valid, never cleared by a pull
                11'h002: fld.qword = {statusOf(1'b1, 1'b0),
                                      56'(fld.lifeCnt[statIdx])};
                // limited count: valid only after the settle time
                11'h003: fld.qword = {statusOf(fld.fieldValid, 1'b1),
                                      56'(fld.limCnt[statIdx])};
                default: fld.qword = 64'h0000_0000_0000_0000;
            endcase
        end
    end

endmodule

/* File: tlrh_media_model.sv */
// tlrh_media_model.sv - media side: answers each sector fetch with 256 words
// assumes: mediaReq is a one-cycle pulse on mclk
`timescale 1ns/10ps
module tlrh_media_model (
    input  wire logic        mclk,
    input  wire logic        mediaReq,
    input  wire logic [47:0] mediaLba,
    output logic             mediaValid,
    output logic [15:0]      mediaWord
);
    logic [8:0] left = 9'h000;
    logic [7:0] tag  = 8'h00;
    logic [7:0] idx  = 8'h00;
    logic [1:0] ph   = 2'h0;
    initial begin
        mediaValid = 1'b0;
        mediaWord  = 16'h0000;
    end
    // gap every fourth cycle so the design sees a slow source too
    always @(posedge mclk) begin
        ph <= ph + 2'h1;
        if (mediaReq) begin
            left <= 9'h100;
            tag  <= mediaLba[7:0];
            idx  <= 8'h00;
            mediaValid <= 1'b0;
        end else if (left != 9'h000 && ph != 2'h0) begin
            mediaValid <= 1'b1;
            mediaWord  <= {tag, idx};
            idx  <= idx + 8'h01;
            left <= left - 9'h001;
        end else begin
            // idle data never repeats the last word
            mediaValid <= 1'b0;
            mediaWord  <= ~mediaWord;
        end
    end
endmodule

/* File: tb.sv */
// tb.sv - self-checking bench of the telemetry log handler
// assumes: media model compiled first
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    logic mclk=0, reset=1, ce=1, cmdValid=0, dataReady=1, regWr=0, regRd=0;
    logic cmdDone, cmdError, busy, dataValid, mediaReq, mediaValid, blockIrq;
    logic [7:0] cmdOpcode=0;
    logic [15:0] cmdCount=0, dataWord, mediaWord;
    logic [47:0] cmdLba=0, mediaLba;
    logic [4:0] statEvent=0;
    logic [3:0] regAddr=0;
    logic [31:0] regWrData=0, regRdData, r;
    logic [15:0] wd [0:49151];
    int n, irqs, err, bad_count=0, compares=0;
    always #20 mclk = ~mclk;
    telemetry_log_read_handler #(.VALID_CYCLES(32'h0000_0010)) dut (.mclk(mclk),
        .reset(reset), .ce(ce), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
        .cmdCount(cmdCount), .cmdLba(cmdLba), .cmdDone(cmdDone), .cmdError(cmdError),
        .busy(busy), .dataWord(dataWord), .dataValid(dataValid), .dataReady(dataReady),
        .mediaReq(mediaReq), .mediaLba(mediaLba), .mediaValid(mediaValid),
        .mediaWord(mediaWord), .blockIrq(blockIrq), .statEvent(statEvent),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData));
    tlrh_media_model media (.mclk(mclk), .mediaReq(mediaReq), .mediaLba(mediaLba),
        .mediaValid(mediaValid), .mediaWord(mediaWord));
    task report_and_stop;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk); regWr <= 1; regAddr <= a; regWrData <= d;
        @(posedge mclk); regWr <= 0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge mclk); regRd <= 1; regAddr <= a;
        @(posedge mclk); regRd <= 0;
        @(negedge mclk); r = regRdData;
    endtask
    // host side stalls one cycle in eight
    task go(input logic [7:0] op, input logic [15:0] c, input logic [47:0] l);
        int i;
        @(posedge mclk); cmdValid <= 1; cmdOpcode <= op; cmdCount <= c; cmdLba <= l;
        @(posedge mclk); cmdValid <= 0;
        n = 0; irqs = 0; err = 0;
        for (i = 0; i < 60000; i++) begin
            @(negedge mclk);
            if (dataValid === 1'b1 && dataReady) begin wd[n] = dataWord; n++; end
            irqs += (blockIrq === 1'b1); err += (cmdError === 1'b1);
            if (cmdDone === 1'b1 || cmdError === 1'b1) break;
            @(posedge mclk); dataReady <= (i % 8 != 7);
        end
        if (i == 60000) begin bad_count++; report_and_stop; end
    endtask
    task automatic t_header;
        int k;
        int ix [11] = '{0, 1, 2, 3, 4, 8, 16, 20, 21, 24, 28};
        logic [15:0] ev [11] = '{16'h4552, 16'h4747, 16'h4C4F, 16'h0000, 16'h0002,
            16'h0001, 16'h0006, 16'h8000, 16'h0001, 16'h4000, 16'h0018};
        // settle time not yet over right after reset
        rd(4'h4); `CHK(r, 32'h0000_0000)
        go(8'h47, 16'h0020, 48'h0000_0000_00C0);
        `CHK(n, 8192)
        for (k = 0; k < 11; k++) `CHK(wd[ix[k]], ev[k])
        `CHK(wd[12] | wd[32] | wd[8191], 16'h0000)
    endtask
    task t_refuse;
        go(8'h47, 16'h001F, 48'h0000_0000_00C0); `CHK(err, 1)
        go(8'h47, 16'h0020, 48'h0001_0000_00C0); `CHK(err, 1)
        go(8'h47, 16'h0040, 48'h0000_0000_05C0); `CHK(err, 1)
    endtask
    task t_pages;
        @(posedge mclk); statEvent <= 5'h01;
        @(posedge mclk); statEvent <= 5'h00;
        go(8'h2F, 16'h0020, 48'h0000_0000_01C0);
        `CHK(wd[0], 16'h0001)
        `CHK({wd[8], wd[11], wd[12], wd[15]}, 64'h0001_C000_0001_E000)
        go(8'h47, 16'h00C0, 48'h0000_0000_00C0);
        `CHK(n, 49152)
        `CHK({wd[8192], wd[8204]}, 32'h0001_0001)
        rd(4'h4); `CHK(r[31:16], 16'h0001)
        `CHK(r[1:0], 2'h2)
        go(8'h47, 16'h0020, 48'h0000_0000_01C0);
        `CHK({wd[8], wd[12]}, 32'h0001_0000)
    endtask
    task t_mult;
        rd(4'h0); `CHK(r, 32'h0000_0001)
        rd(4'hC); `CHK(r, 32'h0000_0000)
        // a write while the clock enable is low must not land
        @(posedge mclk); ce <= 0;
        wr(4'h0, 32'h0000_0005); ce <= 1;
        rd(4'h0); `CHK(r, 32'h0000_0001)
        wr(4'h0, 32'h0000_0002);
        go(8'hC4, 16'h0003, 48'h0000_0000_0010);
        `CHK(n, 768)
        `CHK({wd[0], wd[256], wd[767]}, 48'h1000_1100_12FF)
        `CHK(irqs, 2)
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 0;
        t_header; t_refuse; t_pages; t_mult;
        report_and_stop;
    end
endmodule
